//--- pkg/phc_defines.svh
// Shared constants for the port configuration and reset loader.
// Assumes a single 250 MHz system clock and eight ports.
//
// How it works
// - Reconsult config on power-up, reset, link failure
// - Management mode loads straps, then management owns
// - Hardware mode blocks management register writes
// - Hardware mode samples straps at hardware reset
// - Fiber, forced 100/10 full/half, or negotiation
// - Forced starts link at once, else negotiation
// - Power-down pin stops ports, clock, pads, pulls
// - Power-down hides registers, then restores reset values
// - Port power-down bit stops only that port
// - Hardware reset loads negotiation, speed, duplex from straps
// - Software reset restores last captured strap values
// - Registers unavailable one millisecond after reset
// - Registers readable during software reset; bit self-clears
// - Three strap pins per port, three bits
// - First strap low: forced speed and duplex
// - First strap high: negotiate, straps two and three pick abilities
// - Disable pin high blocks management, straps govern
`ifndef PHC_DEFINES_SVH
`define PHC_DEFINES_SVH
`define PHC_PORTS     8
`define PHC_PW        3
`define PHC_AW        5
`define PHC_DW        16
`define PHC_REG_CTRL  5'h00
`define PHC_REG_ADV   5'h04
`define PHC_REG_AUX   5'h10
`define PHC_B_SRST    15
`define PHC_B_SPEED   13
`define PHC_B_NEG     12
`define PHC_B_PDOWN   11
`define PHC_B_FDX     8
`define PHC_B_AFF     8
`define PHC_B_AFH     7
`define PHC_B_ASF     6
`define PHC_B_ASH     5
`define PHC_B_FIBER   0
`define PHC_ADV_RST   4'hF
`define PHC_CLK_MHZ   250
`define PHC_HOLD_US   1000
`define PHC_HOLD_CYC  (`PHC_HOLD_US * `PHC_CLK_MHZ)
`define PHC_TW        18
`define PHC_SRST_CYC  4'h8
`define PHC_SRST_RD   4'h2
`define PHC_SRST_END  4'h1
`endif

//--- pkg/phc_pkg.sv
// Types shared by the loader and its helpers.
// Assumes phc_defines.svh is on the include path.
`include "phc_defines.svh"
`default_nettype none
package phc_pkg;
  // Link operating selection of one port
  typedef struct packed {
    logic fiber;   // Forced fiber operation
    logic neg;     // Negotiation enable
    logic speed;   // 1: 100, 0: 10
    logic fdx;     // Full duplex
    logic pdown;   // Port power-down
  } phc_mode_t;
  // Advertised abilities of one port
  typedef struct packed {
    logic fast_full;
    logic fast_half;
    logic slow_full;
    logic slow_half;
  } phc_adv_t;
  // Management request
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [`PHC_PW-1:0]   port;
    logic [`PHC_AW-1:0]   addr;
    logic [`PHC_DW-1:0]   wdata;
  } phc_req_t;
  // Chip-level sequence
  typedef enum logic [3:0] {
    ST_PDOWN = 4'h1,
    ST_CAPT  = 4'h2,
    ST_HOLD  = 4'h4,
    ST_RUN   = 4'h8
  } phc_state_t;
  // Control bits from the three straps of a port
  function automatic phc_mode_t phc_strap_mode(input logic [2:0] s);
    phc_mode_t m;
    m.fiber = 1'b0;
    m.neg   = s[0];
    m.speed = s[0] | s[1];
    m.fdx   = s[2];
    m.pdown = 1'b0;
    return m;
  endfunction
  // Advertisement from the straps; forced modes leave the reset value
  function automatic phc_adv_t phc_strap_adv(input logic [2:0] s);
    phc_adv_t a;
    a = s[0] ? {s[2], 1'b1, s[1] & s[2], s[1]} : `PHC_ADV_RST;
    return a;
  endfunction
endpackage
`default_nettype wire

//--- core/phc_strap_shadow.sv
// Shadow store of the straps captured at the last hardware reset.
// Assumes the writer loads all ports at once and reads one at a time.
`include "phc_defines.svh"
`default_nettype none
module phc_strap_shadow (
  input  wire logic                        sys_clk_i,  // System clock
  input  wire logic                        arst_n_i,   // Async reset
  input  wire logic                        wr_all_i,   // Load every entry
  input  wire logic [`PHC_PORTS*3-1:0]     wdata_i,    // Straps, port 0 low
  input  wire logic [`PHC_PW-1:0]          raddr_i,    // Port to read
  output logic      [2:0]                  rdata_o     // Registered read
);
  logic [2:0] mem_q [`PHC_PORTS];  // One entry per port

  // Entries only change on a hardware capture
  for (genvar g = 0; g < `PHC_PORTS; g++) begin : g_ent
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        mem_q[g] <= 3'h0;
      end else if (wr_all_i) begin
        mem_q[g] <= wdata_i[g*3 +: 3];
      end
    end
  end

  // Read data from a flop so restore timing is fixed
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 3'h0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

//--- core/phc_hold_timer.sv
// Down counter that keeps registers hidden after a hardware capture.
// Assumes start is a single-cycle pulse.
`include "phc_defines.svh"
`default_nettype none
module phc_hold_timer #(
  parameter int unsigned HOLD = `PHC_HOLD_CYC  // Cycles to hold
) (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic arst_n_i,   // Async reset
  input  wire logic start_i,    // Restart the hold
  output logic      done_o      // Hold has expired
);
  logic [`PHC_TW-1:0] cnt_q;   // Remaining cycles
  logic               busy_q;  // Counting

  // Count down; a new start always wins over expiry
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= `PHC_TW'(HOLD - 1);
      busy_q <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q  <= cnt_q - `PHC_TW'(1);
    end else begin
      busy_q <= 1'b0;
    end
  end

  assign done_o = busy_q && (cnt_q == '0);
endmodule
`default_nettype wire

//--- core/phc_loader.sv
// Per-port configuration, reset and power-down control.
// Assumes management requests and straps are synchronous to sys_clk_i.
`include "phc_defines.svh"
`default_nettype none
module phc_loader #(
  parameter int unsigned HOLD_CYCLES = `PHC_HOLD_CYC  // Post-reset hold
) (
  input  wire logic                              sys_clk_i,               // 250 MHz
  input  wire logic                              arst_n_i,                // Hard reset
  input  wire logic                              global_power_down_pin_i, // Chip off
  input  wire logic                              mgmt_disable_pin_i,      // Straps rule
  input  wire logic [`PHC_PORTS-1:0][2:0]        led_strap_pin_i,         // Straps
  input  wire logic [`PHC_PORTS-1:0]             link_fail_i,             // Link lost
  input  wire phc_pkg::phc_req_t                 req_i,                   // Mgmt request
  output logic                                   mgmt_ready_o,            // Accepting
  output logic      [`PHC_DW-1:0]                rdata_o,                 // Read data
  output logic                                   rvalid_o,                // Read done
  output phc_pkg::phc_mode_t [`PHC_PORTS-1:0]    mode_o,                  // Link modes
  output phc_pkg::phc_adv_t  [`PHC_PORTS-1:0]    adv_o,                   // Abilities
  output logic      [`PHC_PORTS-1:0]             start_forced_o,          // Go forced
  output logic      [`PHC_PORTS-1:0]             start_neg_o,             // Go negotiate
  output logic      [`PHC_PORTS-1:0]             port_active_o,           // Port on
  output logic                                   pad_oe_o,                // Pads driven
  output logic                                   pull_en_o,               // Pulls on
  output logic                                   clock_run_o              // Clock on
);
  import phc_pkg::*;

  phc_state_t             state_q;     // Chip-level sequence
  logic                   hold_done;   // Post-reset hold over
  logic                   wr_ok;       // Accepted write
  logic [`PHC_PW-1:0]     rd_sel;      // Port whose shadow is read
  logic [2:0]             sh_rdata;    // Shadow read data
  logic [`PHC_PORTS-1:0]  srst_busy;   // Software reset running
  logic [`PHC_PORTS*3-1:0] strap_flat; // Straps in shadow layout
  logic [`PHC_DW-1:0]     rd_word;     // Read mux
  logic [`PHC_PORTS-1:0]  srst_rd;     // Port two cycles before its restore

  assign strap_flat = led_strap_pin_i;

  // Sequence: power-down, capture straps, hold, run
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_CAPT;
    end else if (global_power_down_pin_i) begin
      state_q <= ST_PDOWN;
    end else begin
      unique case (state_q)
        ST_PDOWN: begin
          state_q <= ST_CAPT;  // Leaving power-down acts as hard reset
        end
        ST_CAPT: begin
          state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          if (hold_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Registers stay hidden for the hold after capture
  phc_hold_timer #(
    .HOLD (HOLD_CYCLES)
  ) u_hold (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .start_i   (state_q == ST_CAPT),
    .done_o    (hold_done)
  );

  // Captured straps kept only for later software resets
  phc_strap_shadow u_shadow (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .wr_all_i  (state_q == ST_CAPT),
    .wdata_i   (strap_flat),
    .raddr_i   (rd_sel),
    .rdata_o   (sh_rdata)
  );

  // Disable pin shuts management out entirely
  assign mgmt_ready_o = (state_q == ST_RUN) && !mgmt_disable_pin_i;
  assign wr_ok        = req_i.wr && mgmt_ready_o;

  // Pads, pulls and clock all stop in global power-down
  assign pad_oe_o    = (state_q != ST_PDOWN);
  assign pull_en_o   = (state_q != ST_PDOWN);
  assign clock_run_o = (state_q != ST_PDOWN);

  // Pick the port two cycles before its restore; starts never coincide
  always_comb begin
    rd_sel = '0;
    for (int i = 0; i < `PHC_PORTS; i++) begin
      if (srst_rd[i]) begin
        rd_sel = `PHC_PW'(i);
      end
    end
  end

  for (genvar g = 0; g < `PHC_PORTS; g++) begin : g_port
    phc_mode_t m_q;       // Link mode bits
    phc_adv_t  a_q;       // Advertisement bits
    logic [3:0] scnt_q;   // Software reset countdown
    logic      ev_q;      // Reconsult the configuration
    logic      sel;       // Request aims at this port
    logic      wr_ctrl;   // Control write to this port
    logic      trig;      // Reconsult trigger

    assign sel     = (req_i.port == `PHC_PW'(g));
    assign wr_ctrl = wr_ok && sel && (req_i.addr == `PHC_REG_CTRL);
    assign srst_busy[g] = (scnt_q != 4'h0);
    assign srst_rd[g]   = (scnt_q == `PHC_SRST_RD);  // Flat flag: loop index is not constant

    // Mode and advertisement bits
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        m_q <= '0;
        a_q <= `PHC_ADV_RST;
      end else if (state_q == ST_PDOWN) begin
        m_q <= '0;             // Back to reset values
        a_q <= `PHC_ADV_RST;
      end else if (state_q == ST_CAPT) begin
        m_q <= phc_strap_mode(led_strap_pin_i[g]);
        a_q <= phc_strap_adv(led_strap_pin_i[g]);
      end else if (scnt_q == `PHC_SRST_END) begin
        m_q <= phc_strap_mode(sh_rdata);  // No resample of pins
        a_q <= phc_strap_adv(sh_rdata);
      end else if (wr_ok && sel && !srst_busy[g]) begin
        // Management owns the bits after the load
        if (req_i.addr == `PHC_REG_CTRL) begin
          m_q.speed <= req_i.wdata[`PHC_B_SPEED];
          m_q.neg   <= req_i.wdata[`PHC_B_NEG];
          m_q.pdown <= req_i.wdata[`PHC_B_PDOWN];
          m_q.fdx   <= req_i.wdata[`PHC_B_FDX];
        end else if (req_i.addr == `PHC_REG_ADV) begin
          a_q <= {req_i.wdata[`PHC_B_AFF], req_i.wdata[`PHC_B_AFH],
                  req_i.wdata[`PHC_B_ASF], req_i.wdata[`PHC_B_ASH]};
        end else if (req_i.addr == `PHC_REG_AUX) begin
          m_q.fiber <= req_i.wdata[`PHC_B_FIBER];
        end
      end
    end

    // Reset bit runs a fixed countdown, then clears itself
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        scnt_q <= 4'h0;
      end else if (state_q != ST_RUN) begin
        scnt_q <= 4'h0;
      end else if (wr_ctrl && !srst_busy[g] && req_i.wdata[`PHC_B_SRST]) begin
        scnt_q <= `PHC_SRST_CYC;
      end else if (srst_busy[g]) begin
        scnt_q <= scnt_q - 4'h1;
      end
    end

    // Startup, restore, link failure while running and control writes outside a software reset all reconsult
    assign trig = ((state_q == ST_HOLD) && hold_done)
                || (scnt_q == `PHC_SRST_END)
                || ((state_q == ST_RUN) && link_fail_i[g])
                || (wr_ctrl && !srst_busy[g]);

    // Event is delayed a cycle so it sees the updated mode bits
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ev_q <= 1'b0;
      end else begin
        ev_q <= trig;
      end
    end

    // Forced modes start at once, otherwise negotiation
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        start_forced_o[g] <= 1'b0;
        start_neg_o[g]    <= 1'b0;
      end else begin
        // Fiber overrides negotiation; host must not set both
        start_forced_o[g] <= ev_q && !m_q.pdown && (m_q.fiber || !m_q.neg);
        start_neg_o[g]    <= ev_q && !m_q.pdown && m_q.neg && !m_q.fiber;
      end
    end

    assign mode_o[g]        = m_q;
    assign adv_o[g]         = a_q;
    assign port_active_o[g] = (state_q == ST_RUN) && !m_q.pdown;
  end

  // Read mux; reads stay open during a software reset
  always_comb begin
    rd_word = '0;
    unique case (req_i.addr)
      `PHC_REG_CTRL: begin
        rd_word[`PHC_B_SRST]  = srst_busy[req_i.port];
        rd_word[`PHC_B_SPEED] = mode_o[req_i.port].speed;
        rd_word[`PHC_B_NEG]   = mode_o[req_i.port].neg;
        rd_word[`PHC_B_PDOWN] = mode_o[req_i.port].pdown;
        rd_word[`PHC_B_FDX]   = mode_o[req_i.port].fdx;
      end
      `PHC_REG_ADV: begin
        rd_word[`PHC_B_AFF:`PHC_B_ASH] = adv_o[req_i.port];
      end
      `PHC_REG_AUX: begin
        rd_word[`PHC_B_FIBER] = mode_o[req_i.port].fiber;
      end
      default: begin
        rd_word = '0;  // Unmapped reads as zero
      end
    endcase
  end

  // Read answer one cycle after an accepted request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd && mgmt_ready_o;
      if (req_i.rd && mgmt_ready_o) begin
        rdata_o <= rd_word;
      end
    end
  end

  // Checks, per-port ones on port 0; helper keeps its last captured straps
  logic [2:0] sh0_q;  // Port 0 straps at last capture
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh0_q <= 3'h0;
    end else if (state_q == ST_CAPT) begin
      sh0_q <= led_strap_pin_i[0];
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_srst_go;
    wr_ok && (req_i.port == 3'h0) && (req_i.addr == `PHC_REG_CTRL)
      && req_i.wdata[`PHC_B_SRST] && !srst_busy[0];
  endsequence
  sequence s_srst_run;
    srst_busy[0] [*8] ##1 !srst_busy[0];
  endsequence

  property p_hold;
    (state_q == ST_CAPT) |=> !mgmt_ready_o [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("registers open too soon");

  property p_block_wr;
    (state_q == ST_RUN) && mgmt_disable_pin_i && !srst_busy[0]
      |=> $stable(g_port[0].a_q) && $stable(g_port[0].m_q);
  endproperty
  a_block_wr: assert property (p_block_wr) else $error("write not blocked");

  property p_gpd;
    global_power_down_pin_i |=> !pad_oe_o && !pull_en_o && !clock_run_o && !mgmt_ready_o;
  endproperty
  a_gpd: assert property (p_gpd) else $error("power-down outputs wrong");

  property p_gpd_rst;
    (state_q == ST_PDOWN) |=> (adv_o[0] == `PHC_ADV_RST) && !mode_o[0].neg;
  endproperty
  a_gpd_rst: assert property (p_gpd_rst) else $error("power-down reset lost");

  property p_forced;
    (state_q == ST_CAPT) && !led_strap_pin_i[0][0] |=> !mode_o[0].neg
      && (mode_o[0].speed == $past(led_strap_pin_i[0][1]))
      && (mode_o[0].fdx == $past(led_strap_pin_i[0][2]));
  endproperty
  a_forced: assert property (p_forced) else $error("forced strap decode wrong");

  property p_negotiation_enable_bit;
    (state_q == ST_CAPT) && led_strap_pin_i[0][0] |=> mode_o[0].neg && mode_o[0].speed
      && adv_o[0].fast_half && (adv_o[0].slow_half == $past(led_strap_pin_i[0][1]))
      && (adv_o[0].fast_full == $past(led_strap_pin_i[0][2]));
  endproperty
  a_negotiation_enable_bit: assert property (p_negotiation_enable_bit) else $error("negotiation strap decode wrong");

  property p_srst;
    s_srst_go |=> s_srst_run;
  endproperty
  a_srst: assert property (p_srst) else $error("reset bit timing wrong");

  property p_restore;
    (state_q == ST_RUN) && (g_port[0].scnt_q == `PHC_SRST_END)
      |=> (mode_o[0] == phc_strap_mode(sh0_q)) && (adv_o[0] == phc_strap_adv(sh0_q));
  endproperty
  a_restore: assert property (p_restore) else $error("restore not from capture");

  property p_start;
    g_port[0].ev_q && !mode_o[0].pdown
      |=> (start_neg_o[0] != start_forced_o[0])
      && (start_neg_o[0] == ($past(mode_o[0].neg) && !$past(mode_o[0].fiber)));
  endproperty
  a_start: assert property (p_start) else $error("wrong link start");

  property p_pdown;
    mode_o[0].pdown |-> !port_active_o[0];
  endproperty
  a_pdown: assert property (p_pdown) else $error("powered-down port active");
endmodule
`default_nettype wire

//--- testbench/phc_host.sv
// Station management model: issues single-cycle register requests.
// Assumes the loader takes a request on a rising edge while ready is high.
`include "phc_defines.svh"
`default_nettype none
module phc_host (
  input  wire logic               sys_clk_i,  // System clock
  input  wire logic               ready_i,    // Loader accepting
  input  wire logic               rvalid_i,   // Read answer strobe
  input  wire logic [`PHC_DW-1:0] rdata_i,    // Read answer data
  output var  phc_pkg::phc_req_t  req_o       // Request to loader
);
  timeunit 1ns;
  timeprecision 1ps;
  import phc_pkg::*;

  // Idle at time zero so no strobe is seen during reset
  initial req_o = '0;

  // One transfer launched on a falling edge and held over one taking edge;
  // released lines are inverted so stale values cannot pass for fresh ones
  task automatic xfer(input logic wr, input logic [2:0] port, input logic [4:0] addr,
                      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    logic acc;  // Ready as the taking edge will see it
    @(negedge sys_clk_i);
    req_o = '{wr: wr, rd: ~wr, port: port, addr: addr, wdata: wd};
    acc = ready_i;
    @(negedge sys_clk_i);
    // Writes report acceptance, reads report the answer strobe
    ok = wr ? acc : rvalid_i;
    rd = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, port: ~port, addr: ~addr, wdata: ~wd};
  endtask

  // Poll the reset bit until it reads zero, bounded so a stuck bit ends it
  task automatic poll_reset(input logic [2:0] port, output int n);
    logic [15:0] d;
    logic        ok;
    n = 0;
    do begin
      xfer(1'b0, port, `PHC_REG_CTRL, 16'h0000, d, ok);
      n++;
    end while (d[`PHC_B_SRST] !== 1'b0 && n < 40);
  endtask

  // Fiber is selected only after negotiation has been switched off
  task automatic set_fiber(input logic [2:0] port, input logic [15:0] ctrl);
    logic [15:0] d;
    logic        ok;
    xfer(1'b1, port, `PHC_REG_CTRL, ctrl & ~(16'h0001 << `PHC_B_NEG), d, ok);
    xfer(1'b1, port, `PHC_REG_AUX, 16'h0001, d, ok);
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the port configuration and reset loader.
// Assumes phc_host.sv as the management side; straps are driven here.
`include "phc_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import phc_pkg::*;

  localparam int HOLD = 20;            // Short hold keeps the run brief
  logic                        clk;    // System clock
  logic                        arst_n; // Hardware reset
  logic                        gpd;    // Global power-down pin
  logic                        mdis;   // Management disable pin
  logic [`PHC_PORTS-1:0][2:0]  straps; // Board straps
  logic [`PHC_PORTS-1:0]       lfail;  // Link failure per port
  phc_req_t                    req;    // Management request
  logic                        ready;  // Loader accepting
  logic [`PHC_DW-1:0]          rdata;  // Read data
  logic                        rvalid; // Read strobe
  phc_mode_t [`PHC_PORTS-1:0]  mode;   // Link modes
  phc_adv_t  [`PHC_PORTS-1:0]  adv;    // Advertised abilities
  logic [`PHC_PORTS-1:0]       sfor;   // Forced start pulses
  logic [`PHC_PORTS-1:0]       sneg;   // Negotiation start pulses
  logic [`PHC_PORTS-1:0]       pact;   // Ports running
  logic                        pad_oe; // Pads driven
  logic                        pull;   // Pulls on
  logic                        crun;   // Clock running
  int                          n_errors = 0;
  int                          num_checks = 0;

  phc_loader #(.HOLD_CYCLES(HOLD)) u_phc_loader (
    .sys_clk_i(clk), .arst_n_i(arst_n), .global_power_down_pin_i(gpd),
    .mgmt_disable_pin_i(mdis), .led_strap_pin_i(straps), .link_fail_i(lfail),
    .req_i(req), .mgmt_ready_o(ready), .rdata_o(rdata), .rvalid_o(rvalid),
    .mode_o(mode), .adv_o(adv), .start_forced_o(sfor), .start_neg_o(sneg),
    .port_active_o(pact), .pad_oe_o(pad_oe), .pull_en_o(pull), .clock_run_o(crun));

  phc_host u_phc_host (
    .sys_clk_i(clk), .ready_i(ready), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

  // Constant reference clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected control bits from one port's three straps
  function automatic logic [4:0] exp_mode(input logic [2:0] s);
    return {1'b0, s[0], s[0] | s[1], s[2], 1'b0};
  endfunction
  // Expected advertisement; forced straps leave the reset value
  function automatic logic [3:0] exp_adv(input logic [2:0] s);
    return s[0] ? {s[2], 1'b1, s[1] & s[2], s[1]} : 4'hF;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] port, input logic [4:0] addr, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    u_phc_host.xfer(1'b1, port, addr, d, r, ok);
    check(ok, 1'b1);
  endtask

  task automatic rd(input logic [2:0] port, input logic [4:0] addr, input logic [15:0] e);
    logic [15:0] r;
    logic        ok;
    u_phc_host.xfer(1'b0, port, addr, 16'h0000, r, ok);
    check(ok, 1'b1);
    check(r, e);
  endtask

  // Wait out the hold, then compare every port against its straps
  task automatic settle_check();
    int         n;
    logic [7:0] sf;
    logic [7:0] sn;
    logic [7:0] ef;
    n = 0;
    sf = '0;
    sn = '0;
    while (ready !== 1'b1 && n < HOLD + 20) begin
      @(negedge clk);
      n++;
    end
    check(n >= HOLD && n <= HOLD + 5, 1'b1);
    repeat (4) begin
      sf |= sfor;
      sn |= sneg;
      @(negedge clk);
    end
    for (int p = 0; p < 8; p++) begin
      ef[p] = ~straps[p][0];
      check(mode[p], exp_mode(straps[p]));
      check(adv[p], exp_adv(straps[p]));
    end
    check({sf, sn}, {ef, ~ef});
    check(pact, 8'hFF);
  endtask

  task automatic t_hw_reset();
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    settle_check();
  endtask

  // Forced write takes effect and launches the link; readback matches
  task automatic t_write();
    wr(3'd2, `PHC_REG_CTRL, 16'h2100);
    check(mode[2], 5'b00110);
    @(negedge clk);
    check({sfor, sneg}, 16'h0400);
    rd(3'd2, `PHC_REG_CTRL, 16'h2100);
    rd(3'd2, 5'h02, 16'h0000);
  endtask

  // With the disable pin high, writes and reads are both refused
  task automatic t_hw_mode();
    logic [15:0] d;
    logic        ok;
    mdis = 1'b1;
    @(negedge clk);
    check(ready, 1'b0);
    u_phc_host.xfer(1'b1, 3'd2, `PHC_REG_CTRL, 16'h1000, d, ok);
    check(ok, 1'b0);
    u_phc_host.xfer(1'b1, 3'd0, `PHC_REG_CTRL, 16'h1000, d, ok);
    u_phc_host.xfer(1'b0, 3'd2, `PHC_REG_CTRL, 16'h0000, d, ok);
    check(ok, 1'b0);
    check(mode[2], 5'b00110);
    check(mode[0], 5'b00000);
    mdis = 1'b0;
    @(negedge clk);
  endtask

  // Soft reset restores captured straps even after the pins have moved
  task automatic t_soft_reset();
    int n;
    wr(3'd3, `PHC_REG_CTRL, 16'h0000);
    straps[3] = 3'b110;
    wr(3'd3, `PHC_REG_CTRL, 16'h8000);
    u_phc_host.poll_reset(3'd3, n);
    check(n >= 2 && n <= 8, 1'b1);
    check(mode[3], exp_mode(3'b011));
    check(adv[3], exp_adv(3'b011));
    rd(3'd3, `PHC_REG_CTRL, 16'h3000);
    // Bits written with the reset bit are overridden by the restore
    wr(3'd0, `PHC_REG_CTRL, 16'hB100);
    u_phc_host.poll_reset(3'd0, n);
    check(mode[0], exp_mode(3'b000));
  endtask

  // Port power-down stops one port and keeps its register contents
  task automatic t_port_pdown();
    wr(3'd1, `PHC_REG_CTRL, 16'h3800);
    check(pact, 8'hFD);
    rd(3'd1, `PHC_REG_CTRL, 16'h3800);
  endtask

  task automatic t_link_fail();
    @(negedge clk);
    lfail[5] = 1'b1;
    @(negedge clk);
    lfail = '0;
    @(negedge clk);
    check({sfor, sneg}, 16'h0020);
  endtask

  task automatic t_fiber();
    u_phc_host.set_fiber(3'd6, 16'h3100);
    check(mode[6], 5'b10110);
    rd(3'd6, `PHC_REG_AUX, 16'h0001);
  endtask

  // Global power-down darkens the chip; leaving it resamples the straps
  task automatic t_global_pdown();
    gpd = 1'b1;
    repeat (2) @(negedge clk);
    check({pad_oe, pull, crun, ready}, 4'h0);
    check(pact, 8'h00);
    check(mode[1], 5'b00000);
    straps[0] = 3'b101;  // Port 0 negotiates after this capture
    gpd = 1'b0;
    settle_check();
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(negedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    gpd = 1'b0;
    mdis = 1'b0;
    lfail = '0;
    for (int p = 0; p < 8; p++) begin
      straps[p] = 3'(p);
    end
    t_hw_reset();
    t_write();
    t_hw_mode();
    t_soft_reset();
    t_port_pdown();
    t_link_fail();
    t_fiber();
    t_global_pdown();
    finish_test();
  end
endmodule
`default_nettype wire
